// File: logic/timer_defines.vh
// constants for the event, window and pulse width timer
`ifndef TIMER_DEFINES_VH
`define TIMER_DEFINES_VH
// register byte offsets
`define OFS_CONTROL      8'h00
`define OFS_COMPARE      8'h04
`define OFS_CAPTURE      8'h08
`define OFS_STATUS       8'h0c
// control field positions
`define CTL_START_LSB    0
`define CTL_CLK_LSB      2
`define CTL_MODE_LSB     4
`define CTL_MCAP_BIT     7
`define CTL_METT_BIT     8
`define CTL_ACAP_BIT     9
`define CTL_WIDTH        10
// reset values
`define CONTROL_RST      10'h000
`define COMPARE_RST      16'hffff
`define CAPTURE_RST      16'h0000
`define COUNTER_RST      16'h0000
// start/edge select codes
`define START_STOP       2'h0
`define START_RISE       2'h1
`define START_FALL       2'h2
// mode codes
`define MODE_EVENT       3'h2
`define MODE_WINDOW      3'h3
`define MODE_PULSE       3'h4
// source clock divider limits, one less than the tick period in sys_clk cycles
`define DIV_SEL0         10'h3ff
`define DIV_SEL1         10'h03f
`define DIV_SEL2         10'h003
`define DIV_SEL3         10'h000
// counter held after a single-edge capture
`define COUNT_HOLD       16'h0001
`endif

// File: logic/edge_sync.v
// two-stage synchroniser with edge detection for the timer input pin
`default_nettype none
module edge_sync
(
  input  wire sys_clk,
  input  wire rst_n,
  input  wire pin_in,
  output wire level,
  output wire rise,
  output wire fall
);
  reg meta_ff;
  reg sync_ff;
  reg last_ff;

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= pin_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff & ~last_ff;
  assign fall  = ~sync_ff & last_ff;
endmodule // edge_sync
`default_nettype wire

// File: logic/timer_event_window_pulse_width.v
// event counter, window and pulse width timer with ahb-lite registers
`default_nettype none
`include "timer_defines.vh"
module timer_event_window_pulse_width
(
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  input  wire        timer_input_pin,
  input  wire        stop_mode_req,
  output wire        timer_match_irq
);
  // bus state
  reg                     wr_pend_ff;
  reg  [7:0]              wr_addr_ff;
  reg  [31:0]             rdata_ff;
  // registers
  reg  [`CTL_WIDTH-1:0]   timer_control_reg_ff;
  reg  [15:0]             compare_pending_ff;
  reg                     compare_new_ff;
  reg  [15:0]             compare_limit_reg_ff;
  reg  [15:0]             capture_value_reg_ff;
  reg  [15:0]             counter_ff;
  reg  [9:0]              prescale_ff;
  reg                     pw_run_ff;
  reg                     pw_second_ff;
  reg                     irq_ff;
  // next values
  reg  [15:0]             nxt_counter;
  reg  [15:0]             nxt_capture;
  reg                     nxt_pw_run;
  reg                     nxt_pw_second;
  reg                     nxt_irq;
  reg  [9:0]              div_limit;
  // decoded control
  wire [1:0]              start_edge_select;
  wire [1:0]              source_clock_select;
  wire [2:0]              mode;
  wire                    capture_edge_mode;
  wire                    trigger_stop_mode;
  wire                    auto_capture_enable;
  wire                    running;
  wire                    tick;
  wire                    pin_level;
  wire                    pin_rise;
  wire                    pin_fall;
  wire                    trig_edge;
  wire                    opp_edge;
  wire                    match;
  wire                    window_open;
  wire                    addr_phase;
  wire [7:0]              addr_ofs;

  assign start_edge_select   = timer_control_reg_ff[`CTL_START_LSB +: 2];
  assign source_clock_select = timer_control_reg_ff[`CTL_CLK_LSB +: 2];
  assign mode                = timer_control_reg_ff[`CTL_MODE_LSB +: 3];
  assign capture_edge_mode   = timer_control_reg_ff[`CTL_MCAP_BIT];
  assign trigger_stop_mode   = timer_control_reg_ff[`CTL_METT_BIT];
  assign auto_capture_enable = timer_control_reg_ff[`CTL_ACAP_BIT];
  assign running             = (start_edge_select != `START_STOP);

  // input pin synchroniser and edge detect
  edge_sync u_pin_sync
  (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_in  (timer_input_pin),
    .level   (pin_level),
    .rise    (pin_rise),
    .fall    (pin_fall)
  );

  // trigger edge is the selected edge, opp_edge the other one
  assign trig_edge = (start_edge_select == `START_RISE) ? pin_rise : pin_fall;
  assign opp_edge  = (start_edge_select == `START_RISE) ? pin_fall : pin_rise;
  assign match     = (counter_ff == compare_limit_reg_ff);
  // positive polarity with rising select, negative otherwise
  assign window_open = (start_edge_select == `START_RISE) ?
                       pin_level : ~pin_level;

  // internal source clock as a one-cycle enable
  always @*
  begin
    case (source_clock_select)
      2'h0:    div_limit = `DIV_SEL0;
      2'h1:    div_limit = `DIV_SEL1;
      2'h2:    div_limit = `DIV_SEL2;
      default: div_limit = `DIV_SEL3;
    endcase
  end

  assign tick = (prescale_ff >= div_limit);

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      prescale_ff <= 10'h000;
    end
    else if (tick)
    begin
      prescale_ff <= 10'h000;
    end
    else
    begin
      prescale_ff <= prescale_ff + 10'h001;
    end
  end

  // counting, capture and interrupt behaviour per mode
  always @*
  begin
    nxt_counter   = counter_ff;
    nxt_capture   = capture_value_reg_ff;
    nxt_pw_run    = pw_run_ff;
    nxt_pw_second = pw_second_ff;
    nxt_irq       = 1'b0;
    if (!running)
    begin
      nxt_pw_run    = 1'b0;
      nxt_pw_second = 1'b0;
    end
    else
    begin
      case (mode)
        `MODE_EVENT:
        begin
          if (opp_edge && match)
          begin
            nxt_irq     = 1'b1;
            nxt_counter = `COUNTER_RST;
          end
          else if (trig_edge)
          begin
            nxt_counter = counter_ff + 16'h0001;
          end
          if (auto_capture_enable && tick)
          begin
            nxt_capture = counter_ff;
          end
        end
        `MODE_WINDOW:
        begin
          if (tick && window_open)
          begin
            if (match)
            begin
              nxt_irq     = 1'b1;
              nxt_counter = `COUNTER_RST;
            end
            else
            begin
              nxt_counter = counter_ff + 16'h0001;
            end
          end
          if (auto_capture_enable && tick)
          begin
            nxt_capture = counter_ff;
          end
        end
        `MODE_PULSE:
        begin
          if (!pw_run_ff)
          begin
            if (trig_edge)
            begin
              nxt_pw_run    = 1'b1;
              nxt_pw_second = 1'b0;
            end
          end
          else if (opp_edge && !pw_second_ff)
          begin
            nxt_capture = counter_ff;
            nxt_irq     = 1'b1;
            if (capture_edge_mode)
            begin
              nxt_counter = `COUNT_HOLD;
              nxt_pw_run  = 1'b0;
            end
            else
            begin
              nxt_pw_second = 1'b1;
              if (tick)
              begin
                nxt_counter = counter_ff + 16'h0001;
              end
            end
          end
          else if (trig_edge && pw_second_ff)
          begin
            nxt_capture   = counter_ff;
            nxt_irq       = 1'b1;
            nxt_counter   = `COUNTER_RST;
            nxt_pw_second = 1'b0;
          end
          else if (tick)
          begin
            nxt_counter = counter_ff + 16'h0001;
          end
        end
        default:
        begin
          nxt_pw_run = 1'b0;
        end
      endcase
    end
  end

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      counter_ff           <= `COUNTER_RST;
      capture_value_reg_ff <= `CAPTURE_RST;
      pw_run_ff            <= 1'b0;
      pw_second_ff         <= 1'b0;
      irq_ff               <= 1'b0;
    end
    else if (stop_mode_req)
    begin
      pw_run_ff    <= 1'b0;
      pw_second_ff <= 1'b0;
      irq_ff       <= 1'b0;
    end
    else
    begin
      counter_ff           <= nxt_counter;
      capture_value_reg_ff <= nxt_capture;
      pw_run_ff            <= nxt_pw_run;
      pw_second_ff         <= nxt_pw_second;
      irq_ff               <= nxt_irq;
    end
  end

  assign timer_match_irq = irq_ff;

  // compare value loads into the limit on the next source tick
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      compare_limit_reg_ff <= `COMPARE_RST;
    end
    else if (tick && compare_new_ff)
    begin
      compare_limit_reg_ff <= compare_pending_ff;
    end
  end

  // ahb-lite slave, zero wait states, always okay
  assign addr_phase = hsel & htrans[1] & hready;
  assign addr_ofs   = haddr[7:0];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = rdata_ff;

  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff   <= 32'h00000000;
    end
    else
    begin
      wr_pend_ff <= addr_phase & hwrite;
      if (addr_phase)
      begin
        wr_addr_ff <= addr_ofs;
      end
      if (addr_phase && !hwrite)
      begin
        case (addr_ofs)
          `OFS_CONTROL:
            rdata_ff <= {22'h000000, timer_control_reg_ff};
          `OFS_COMPARE:
            rdata_ff <= {16'h0000, compare_limit_reg_ff};
          `OFS_CAPTURE:
            rdata_ff <= {16'h0000, capture_value_reg_ff};
          `OFS_STATUS:
            rdata_ff <= {14'h0000, pw_second_ff, pw_run_ff, counter_ff};
          default:
            rdata_ff <= 32'h00000000;
        endcase
      end
    end
  end

  // control and compare writes in the data phase
  always @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      timer_control_reg_ff <= `CONTROL_RST;
      compare_pending_ff   <= `COMPARE_RST;
      compare_new_ff       <= 1'b0;
    end
    else
    begin
      if (wr_pend_ff && wr_addr_ff == `OFS_CONTROL)
      begin
        timer_control_reg_ff <= hwdata[`CTL_WIDTH-1:0];
      end
      if (stop_mode_req)
      begin
        timer_control_reg_ff[`CTL_START_LSB +: 2] <= `START_STOP;
      end
      if (wr_pend_ff && wr_addr_ff == `OFS_COMPARE)
      begin
        compare_pending_ff <= hwdata[15:0];
        compare_new_ff     <= 1'b1;
      end
      else if (tick)
      begin
        compare_new_ff <= 1'b0;
      end
    end
  end

  // held for software readback only in these modes
  wire unused_mett;
  assign unused_mett = trigger_stop_mode;
endmodule // timer_event_window_pulse_width
`default_nettype wire

// File: bench/pulse_source.sv
// external pulse source model for the timer input pin
`default_nettype none
module pulse_source
(
  input  wire logic sys_clk,
  output var  logic pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin = 1'b0;
  // set a level and hold it, never under two cycles
  task automatic drive(input logic v, input int n);
    pin <= v;
    repeat ((n < 2) ? 2 : n) @(posedge sys_clk);
  endtask
endmodule // pulse_source
`default_nettype wire

// File: bench/timer_checker.sv
// port assertions for the event, window and pulse width timer
`default_nettype none
module timer_checker
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        stop_mode_req,
  input wire logic        timer_match_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  wire rd_go = hsel && htrans[1] && hready && !hwrite;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  sequence stop2;
    stop_mode_req [*2];
  endsequence
  sequence quiet3;
    !timer_match_irq [*3];
  endsequence
  bus_ready_a:
    assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a:
    assert property (!hresp)
    else $error("hresp set");
  irq_pulse_a:
    assert property (timer_match_irq |=> !timer_match_irq)
    else $error("irq too long");
  rdata_hold_a:
    assert property (!rd_go |=> $stable(hrdata))
    else $error("hrdata changed");
  upper_zero_a:
    assert property (hrdata[31:18] == 14'h0)
    else $error("hrdata upper set");
  stop_quiet_a:
    assert property (stop2 |-> !timer_match_irq)
    else $error("irq in stop");
  reset_clear_a:
    assert property (disable iff (1'b0)
      !rst_n |=> hrdata == 32'h0 && !timer_match_irq)
    else $error("reset not clear");
  start_quiet_a:
    assert property ($rose(rst_n) |-> quiet3)
    else $error("irq after reset");
endmodule // timer_checker
bind timer_event_window_pulse_width timer_checker i_timer_checker
(
  .sys_clk, .rst_n, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp,
  .hrdata, .stop_mode_req, .timer_match_irq
);
`default_nettype wire

// File: bench/timer_event_window_pulse_width_bench.sv
// self-checking bench for the event, window and pulse width timer
`default_nettype none
`include "timer_defines.vh"
module timer_event_window_pulse_width_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        stop_mode_req = 1'b0;
  logic        lvl = 1'b1;
  logic [31:0] rd;
  logic [15:0] a [3];
  logic [15:0] b [3];
  wire         hready;
  wire  [31:0] hrdata;
  wire         pin;
  wire         timer_match_irq;
  int          num_errors = 0;
  int          comparisons = 0;
  int          irqs = 0;
  initial forever #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
    if (!rst_n)
      irqs <= 0;
    else if (timer_match_irq === 1'b1)
      irqs <= irqs + 1;
  pulse_source i_pulse_source (.sys_clk, .pin);
  timer_event_window_pulse_width i_timer_event_window_pulse_width
  (
    .sys_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hreadyout(hready), .hresp(), .hrdata,
    .timer_input_pin(pin), .stop_mode_req, .timer_match_irq
  );
  task automatic print_verdict();
    if (num_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rdy();
    repeat (50)
    begin
      @(posedge sys_clk);
      if (hready === 1'b1)
        return;
    end
    num_errors++;
    print_verdict();
  endtask
  task automatic bus(input logic w, input logic [7:0] ad,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, ad};
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task automatic rc(input string s, input logic [7:0] ad,
                    input logic [31:0] e);
    bus(1'b0, ad, 32'h0);
    chk(s, e, rd);
  endtask
  task automatic p(input logic v, input int n);
    i_pulse_source.drive(v, n);
  endtask
  task automatic rst();
    rst_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    p(!lvl, 2);
  endtask
  task automatic start(input logic [31:0] cmp, input logic [31:0] ctl,
                       input logic [1:0] s);
    rst();
    bus(1'b1, `OFS_COMPARE, cmp);
    bus(1'b1, `OFS_CONTROL, ctl);
    bus(1'b1, `OFS_CONTROL, ctl | s);
  endtask
  initial
  begin
    rst();
    rc("ctl", `OFS_CONTROL, 32'h0);
    rc("cmp", `OFS_COMPARE, 32'hffff);
    rc("sts", `OFS_STATUS, 32'h0);
    bus(1'b1, `OFS_CAPTURE, 32'h55);
    bus(1'b1, 8'h10, 32'h55);
    rc("cap", `OFS_CAPTURE, 32'h0);
    rc("gap", 8'h10, 32'h0);
    // new compare waits for a source tick, slow divider first
    bus(1'b1, `OFS_COMPARE, 32'h1234);
    rc("cmp", `OFS_COMPARE, 32'hffff);
    bus(1'b1, `OFS_CONTROL, 32'h00c);
    rc("ctl", `OFS_CONTROL, 32'h00c);
    rc("cmp", `OFS_COMPARE, 32'h1234);
    // event counting on each edge kind, with auto-capture
    for (logic [1:0] e = 2'h1; e < 2'h3; e++)
    begin
      lvl = (e == 2'h1);
      start(32'h2, 32'h22c, e);
      p(lvl, 6);
      p(!lvl, 6);
      rc("sts", `OFS_STATUS, 32'h1);
      rc("cap", `OFS_CAPTURE, 32'h1);
      p(lvl, 6);
      rc("sts", `OFS_STATUS, 32'h2);
      chk("irq", 32'h0, irqs);
      p(!lvl, 6);
      chk("irq", 32'h1, irqs);
      rc("sts", `OFS_STATUS, 32'h0);
      p(lvl, 6);
      rc("sts", `OFS_STATUS, 32'h1);
    end
    // window counting in both polarities
    for (logic [1:0] e = 2'h1; e < 2'h3; e++)
    begin
      lvl = (e == 2'h1);
      start(32'h5, 32'h03c, e);
      p(!lvl, 8);
      rc("win", `OFS_STATUS, 32'h0);
      p(lvl, 4);
      p(!lvl, 8);
      rc("win", `OFS_STATUS, 32'h4);
      p(lvl, 3);
      p(!lvl, 8);
      rc("win", `OFS_STATUS, 32'h1);
      chk("irq", 32'h1, irqs);
    end
    // pulse width, double-edge then single-edge
    lvl = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      start(32'hffff, m ? 32'h0cc : 32'h04c, 2'h1);
      for (int k = 0; k < 3; k++)
      begin
        p(1'b1, 10);
        chk("irq", m ? k : 2 * k, irqs);
        bus(1'b0, `OFS_CAPTURE, 32'h0);
        b[k] = rd[15:0];
        p(1'b0, 10);
        chk("irq", m ? k + 1 : 2 * k + 1, irqs);
        bus(1'b0, `OFS_CAPTURE, 32'h0);
        a[k] = rd[15:0];
        bus(1'b0, `OFS_STATUS, 32'h0);
        if (m)
          chk("hold", 32'h1, rd & 32'hffff);
      end
      if (m)
      begin
        chk("cap", a[0] + 32'h1, a[1]);
        chk("cap", a[1], a[2]);
      end
      else
      begin
        chk("cycle", a[0] + 32'd14, b[1]);
        chk("cycle", a[1] + 32'd14, b[2]);
        chk("cap", a[1], a[2]);
      end
    end
    // stop mode clears the start field and freezes counting
    start(32'h10, 32'h02c, 2'h1);
    p(1'b1, 6);
    p(1'b0, 6);
    stop_mode_req <= 1'b1;
    p(1'b1, 6);
    p(1'b0, 6);
    rc("ctl", `OFS_CONTROL, 32'h02c);
    stop_mode_req <= 1'b0;
    p(1'b1, 6);
    rc("sts", `OFS_STATUS, 32'h1);
    bus(1'b1, `OFS_CONTROL, 32'h02d);
    p(1'b0, 6);
    p(1'b1, 6);
    rc("sts", `OFS_STATUS, 32'h2);
    // window on a divide-by-four source with auto-capture
    lvl = 1'b1;
    start(32'hffff, 32'h238, 2'h1);
    p(1'b1, 40);
    p(1'b0, 8);
    rc("win", `OFS_STATUS, 32'ha);
    rc("cap", `OFS_CAPTURE, 32'ha);
    chk("irq", 32'h0, irqs);
    print_verdict();
  end
endmodule // timer_event_window_pulse_width_bench
`default_nettype wire
